/* src/byte_store_pkg.sv */
// constants for the host-side controller of a byte-wide nonvolatile store
// What this block does
// - device select low for every access; nothing happens while it is high
// - write needs select and strobe low with output drive enable high
// - host polls a known location until it matches or the poll limit runs out, then reports done or timeout and goes idle
// - around power changes keep drive enable low, strobe or select high
package byte_store_pkg;
   localparam int ADDR_W = 11;
   localparam int DATA_W = 8;
   localparam int CLK_NS = 25;
   // strobe low time, well above the glitch limit
   localparam int STROBE_NS = 250;
   localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
   localparam int GLITCH_NS = 20;
   localparam int GLITCH_CYC = (GLITCH_NS + CLK_NS - 1) / CLK_NS;
   // setup before strobe and read access time
   localparam int SETUP_NS = 50;
   localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
   localparam int ACCESS_NS = 500;
   localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
   // worst-case programming time, longest time rounds down
   localparam int PROG_MS = 10;
   localparam int PROG_CYC_DEF = PROG_MS * 1000000 / CLK_NS;
   localparam int CNT_W = 20;
   localparam logic [ADDR_W-1:0] ADDR_RST = 11'h000;
   localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
endpackage

/* src/phase_timer.sv */
// down-counter that pulses done after a loaded number of cycles
`timescale 1ns/1ps
module phase_timer (
   input wire logic clk,
   input wire logic rst,
   input wire logic load,
   input wire logic [byte_store_pkg::CNT_W-1:0] count,
   output logic done
);
   logic [byte_store_pkg::CNT_W-1:0] cnt_q, cnt_d;
   logic run_q, run_d;
   // next count
   always_comb begin
      cnt_d = cnt_q;
      run_d = run_q;
      done = run_q && (cnt_q == '0);
      if (load) begin
         cnt_d = count;
         run_d = 1'b1;
      end else if (done) begin
         run_d = 1'b0;
      end else if (run_q) begin
         cnt_d = cnt_q - 1'b1;
      end
   end
   // register
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_q <= '0;
         run_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         run_q <= run_d;
      end
   end
endmodule // phase_timer

/* src/byte_store_host.sv */
// host controller driving the byte-wide store through its pins
`timescale 1ns/1ps
module byte_store_host #(
   parameter int PROG_CYC = byte_store_pkg::PROG_CYC_DEF
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic req,
   input wire logic req_write,
   input wire logic req_poll,
   input wire logic [byte_store_pkg::ADDR_W-1:0] req_addr,
   input wire logic [byte_store_pkg::DATA_W-1:0] req_data,
   output logic busy,
   output logic done,
   output logic timeout,
   output logic [byte_store_pkg::DATA_W-1:0] rd_data,
   output logic [byte_store_pkg::ADDR_W-1:0] location_select_lines,
   input wire logic [byte_store_pkg::DATA_W-1:0] byte_bus_lines_i,
   output logic [byte_store_pkg::DATA_W-1:0] byte_bus_lines_o,
   output logic byte_bus_lines_oe_n,
   output logic select_n,
   output logic drive_en_n,
   output logic strobe_n
);
   typedef enum logic [2:0] {
      IDLE = 3'b000,
      RD_ACC = 3'b001,
      RD_END = 3'b010,
      WR_SET = 3'b011,
      WR_PULSE = 3'b100,
      WR_HOLD = 3'b101,
      POLL_WAIT = 3'b110
   } state_t;

   state_t st_q, st_d;
   logic [byte_store_pkg::ADDR_W-1:0] addr_q, addr_d;
   logic [byte_store_pkg::DATA_W-1:0] wdat_q, wdat_d, rdat_q, rdat_d;
   logic poll_q, poll_d, busy_q, busy_d, done_q, done_d, tmo_q, tmo_d;
   logic sel_q, sel_d, oe_q, oe_d, we_q, we_d, bus_q, bus_d;
   logic [byte_store_pkg::CNT_W-1:0] prog_q, prog_d;
   logic [byte_store_pkg::DATA_W-1:0] in_s1_q, in_s2_q, in_s3_q;
   logic tload;
   logic [byte_store_pkg::CNT_W-1:0] tcount;
   logic tdone;

   // read data from the pins: three stages, take when stages two and three agree
   always_ff @(posedge clk) begin
      if (rst) begin
         in_s1_q <= byte_store_pkg::DATA_RST;
         in_s2_q <= byte_store_pkg::DATA_RST;
         in_s3_q <= byte_store_pkg::DATA_RST;
      end else begin
         in_s1_q <= byte_bus_lines_i;
         in_s2_q <= in_s1_q;
         in_s3_q <= in_s2_q;
      end
   end

   phase_timer u_phase_timer (
      .clk(clk),
      .rst(rst),
      .load(tload),
      .count(tcount),
      .done(tdone)
   );

   // sequencer next state
   always_comb begin
      st_d = st_q;
      addr_d = addr_q;
      wdat_d = wdat_q;
      rdat_d = rdat_q;
      poll_d = poll_q;
      busy_d = busy_q;
      done_d = 1'b0;
      tmo_d = 1'b0;
      sel_d = sel_q;
      oe_d = oe_q;
      we_d = we_q;
      bus_d = bus_q;
      prog_d = prog_q;
      tload = 1'b0;
      tcount = '0;
      unique case (st_q)
         IDLE: begin
            // select high between accesses parks the device in standby
            sel_d = 1'b1;
            oe_d = 1'b1;
            we_d = 1'b1;
            bus_d = 1'b1;
            if (req) begin
               addr_d = req_addr;
               wdat_d = req_data;
               poll_d = req_poll;
               busy_d = 1'b1;
               // fresh poll limit, so no leftover count from an earlier write
               prog_d = byte_store_pkg::CNT_W'(PROG_CYC);
               sel_d = 1'b0;
               tload = 1'b1;
               if (req_write) begin
                  st_d = WR_SET;
                  tcount = byte_store_pkg::CNT_W'(byte_store_pkg::SETUP_CYC);
               end else begin
                  oe_d = 1'b0;
                  st_d = RD_ACC;
                  tcount = byte_store_pkg::CNT_W'(byte_store_pkg::ACCESS_CYC);
               end
            end
         end
         RD_ACC: begin
            if (tdone && in_s2_q == in_s3_q) begin
               rdat_d = in_s3_q;
               sel_d = 1'b1;
               oe_d = 1'b1;
               st_d = RD_END;
            end else if (tdone) begin
               // pins still settling when time ran out: look again next cycle
               tload = 1'b1;
            end
         end
         RD_END: begin
            if (poll_q) begin
               // keep polling until the known value reads back or the poll limit runs out
               if (rdat_q == wdat_q) begin
                  busy_d = 1'b0;
                  done_d = 1'b1;
                  st_d = IDLE;
               end else if (prog_q == '0) begin
                  busy_d = 1'b0;
                  tmo_d = 1'b1;
                  st_d = IDLE;
               end else begin
                  sel_d = 1'b0;
                  oe_d = 1'b0;
                  tload = 1'b1;
                  tcount = byte_store_pkg::CNT_W'(byte_store_pkg::ACCESS_CYC);
                  st_d = RD_ACC;
               end
            end else begin
               busy_d = 1'b0;
               done_d = 1'b1;
               st_d = IDLE;
            end
         end
         WR_SET: begin
            // drive enable stays high, address steady before strobe falls
            bus_d = 1'b0;
            if (tdone) begin
               we_d = 1'b0;
               tload = 1'b1;
               tcount = byte_store_pkg::CNT_W'(byte_store_pkg::STROBE_CYC);
               st_d = WR_PULSE;
            end
         end
         WR_PULSE: begin
            if (tdone) begin
               we_d = 1'b1;
               st_d = WR_HOLD;
            end
         end
         WR_HOLD: begin
            // release bus and wait out programming
            sel_d = 1'b1;
            bus_d = 1'b1;
            prog_d = byte_store_pkg::CNT_W'(PROG_CYC);
            st_d = POLL_WAIT;
         end
         POLL_WAIT: begin
            if (prog_q != '0) begin
               prog_d = prog_q - 1'b1;
            end
            if (poll_q) begin
               sel_d = 1'b0;
               oe_d = 1'b0;
               tload = 1'b1;
               tcount = byte_store_pkg::CNT_W'(byte_store_pkg::ACCESS_CYC);
               st_d = RD_ACC;
            end else if (prog_q == '0) begin
               busy_d = 1'b0;
               done_d = 1'b1;
               st_d = IDLE;
            end
         end
         default: begin
            st_d = IDLE;
         end
      endcase
      if (st_q == RD_ACC || st_q == RD_END) begin
         if (prog_q != '0) begin
            prog_d = prog_q - 1'b1;
         end
      end
   end

   // sequencer registers
   always_ff @(posedge clk) begin
      if (rst) begin
         st_q <= IDLE;
         addr_q <= byte_store_pkg::ADDR_RST;
         wdat_q <= byte_store_pkg::DATA_RST;
         rdat_q <= byte_store_pkg::DATA_RST;
         poll_q <= 1'b0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
         tmo_q <= 1'b0;
         sel_q <= 1'b1;
         oe_q <= 1'b1;
         we_q <= 1'b1;
         bus_q <= 1'b1;
         prog_q <= '0;
      end else begin
         st_q <= st_d;
         addr_q <= addr_d;
         wdat_q <= wdat_d;
         rdat_q <= rdat_d;
         poll_q <= poll_d;
         busy_q <= busy_d;
         done_q <= done_d;
         tmo_q <= tmo_d;
         sel_q <= sel_d;
         oe_q <= oe_d;
         we_q <= we_d;
         bus_q <= bus_d;
         prog_q <= prog_d;
      end
   end

   assign busy = busy_q;
   assign done = done_q;
   assign timeout = tmo_q;
   assign rd_data = rdat_q;
   assign location_select_lines = addr_q;
   assign byte_bus_lines_o = wdat_q;
   assign byte_bus_lines_oe_n = bus_q;
   assign select_n = sel_q;
   assign drive_en_n = oe_q;
   assign strobe_n = we_q;

   // strobe low only with select low and drive enable high
   write_combo_a: assert property (@(posedge clk) disable iff (rst)
      !strobe_n |-> (!select_n && drive_en_n)) else $error("bad write combination");
   // host never drives while device drives
   no_contend_a: assert property (@(posedge clk) disable iff (rst)
      !drive_en_n |-> byte_bus_lines_oe_n) else $error("bus contention");
   // strobe low lasts at least two cycles, never a glitch
   strobe_width_a: assert property (@(posedge clk) disable iff (rst)
      $fell(strobe_n) |-> !strobe_n [*2]) else $error("strobe too short");
   // data on bus whenever strobe rises
   data_held_a: assert property (@(posedge clk) disable iff (rst)
      $rose(strobe_n) |-> !$past(byte_bus_lines_oe_n)) else $error("data not driven");
   // address steady through the strobe
   addr_steady_a: assert property (@(posedge clk) disable iff (rst)
      !strobe_n |-> $stable(location_select_lines)) else $error("address moved");
   // select released after a write
   select_release_a: assert property (@(posedge clk) disable iff (rst)
      $rose(strobe_n) |-> ##1 select_n) else $error("select not released");
   // idle keeps select high
   idle_standby_a: assert property (@(posedge clk) disable iff (rst)
      !busy && !$past(busy) |-> select_n) else $error("select low while idle");
   // drive enable low only with select low
   read_select_a: assert property (@(posedge clk) disable iff (rst)
      !drive_en_n |-> !select_n) else $error("read without select");
endmodule // byte_store_host

/* test/store_model.sv */
// behavioural model of the byte-wide nonvolatile store seen from its pins
`timescale 1ns/1ps
module store_model #(
   parameter int PROG_NS = 800
) (
   input wire logic select_n,
   input wire logic drive_en_n,
   input wire logic strobe_n,
   input wire logic [byte_store_pkg::ADDR_W-1:0] location_select_lines,
   input wire logic [byte_store_pkg::DATA_W-1:0] byte_bus_in,
   output logic [byte_store_pkg::DATA_W-1:0] byte_bus_out,
   output logic byte_bus_drive,
   output int writes
);
   logic [7:0] mem [0:2047];
   logic [10:0] wr_addr;
   logic armed = 1'b0;
   logic prog = 1'b0;
   realtime low_t;
   // write window open; drive enable low inhibits it
   wire wr_act = !select_n && !strobe_n && drive_en_n;
   // erased array reads as zero
   initial begin
      writes = 0;
      for (int i = 0; i < 2048; i++) mem[i] = 8'h00;
   end
   // address at window start, data at window end, short pulses dropped
   always @(wr_act) begin
      if (wr_act === 1'b1) begin
         wr_addr = location_select_lines;
         low_t = $realtime;
         armed = 1'b1;
      end else if (armed) begin
         armed = 1'b0;
         if (!prog && ($realtime - low_t) >= 20.0) begin
            mem[wr_addr] = byte_bus_in;
            writes++;
            prog = 1'b1;
            prog <= #(PROG_NS) 1'b0;
         end
      end
   end
   // drive only while selected, enabled and not programming
   assign byte_bus_drive = !select_n && !drive_en_n && !prog;
   assign byte_bus_out = mem[location_select_lines];
endmodule // store_model

/* test/eeprom_async_byte_access_bench.sv */
// self-checking bench for the host controller against the store model
`timescale 1ns/1ps
module eeprom_async_byte_access_bench;
   localparam int PCYC = 50;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic req = 1'b0;
   logic req_write = 1'b0;
   logic req_poll = 1'b0;
   logic [10:0] req_addr = 11'h000;
   logic [7:0] req_data = 8'h00;
   logic busy, done, timeout, select_n, drive_en_n, strobe_n, bus_oe_n, dev_en;
   logic [7:0] rd_data, bus_o, dev_q, bus_i;
   logic [7:0] last = 8'h00;
   logic [10:0] loc;
   logic [7:0] shadow [0:2047];
   logic [31:0] lfsr = 32'hE03B8F09;
   int writes;
   int exp_writes = 0;
   int miscompares = 0;
   int comparisons = 0;
   always #12.5 clk = ~clk;
   byte_store_host #(.PROG_CYC(PCYC)) u_byte_store_host (.clk(clk), .rst(rst), .req(req),
      .req_write(req_write), .req_poll(req_poll), .req_addr(req_addr), .req_data(req_data),
      .busy(busy), .done(done), .timeout(timeout), .rd_data(rd_data),
      .location_select_lines(loc), .byte_bus_lines_i(bus_i), .byte_bus_lines_o(bus_o),
      .byte_bus_lines_oe_n(bus_oe_n), .select_n(select_n), .drive_en_n(drive_en_n),
      .strobe_n(strobe_n));
   store_model #(.PROG_NS(800)) u_store_model (.select_n(select_n), .drive_en_n(drive_en_n),
      .strobe_n(strobe_n), .location_select_lines(loc), .byte_bus_in(bus_i),
      .byte_bus_out(dev_q), .byte_bus_drive(dev_en), .writes(writes));
   // wire level; a released bus shows the inverse of its last value
   always @* begin
      if (!bus_oe_n) bus_i = bus_o;
      else if (dev_en === 1'b1) bus_i = dev_q;
      else bus_i = ~last;
   end
   always @(posedge clk) begin
      if (!bus_oe_n) last <= bus_o;
      else if (dev_en === 1'b1) last <= dev_q;
   end
   function automatic logic [31:0] step(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (exp !== got) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic results();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // one access; optional second request while busy must be ignored
   task automatic access(input logic w, input logic p, input logic [10:0] a,
      input logic [7:0] d, input logic exp_to, input logic intr);
      int n;
      @(posedge clk);
      #2;
      req = 1'b1;
      req_write = w;
      req_poll = p;
      req_addr = a;
      req_data = d;
      @(posedge clk);
      #2;
      req = 1'b0;
      check("busy", 1'b1, busy);
      n = 0;
      while (done !== 1'b1 && timeout !== 1'b1 && n < 4000) begin
         @(posedge clk);
         #2;
         req = intr && n == 5;
         req_addr = a ^ 11'h001;
         req_data = ~d;
         n++;
      end
      req = 1'b0;
      if (n >= 4000) begin
         miscompares++;
         $display("BAD wait expected done seen none");
         results();
      end
      check("end flags", {~exp_to, exp_to}, {done, timeout});
   endtask
   // pin discipline while running
   always @(posedge clk) begin
      // look once the pins have settled after the edge
      #1;
      if (!rst && strobe_n === 1'b0) check("write pins", 2'b01, {select_n, drive_en_n});
      if (!rst && dev_en === 1'b1) check("bus owner", 1'b1, bus_oe_n);
   end
   initial begin
      logic [10:0] a;
      logic [7:0] d;
      for (int i = 0; i < 2048; i++) shadow[i] = 8'h00;
      repeat (2) @(posedge clk);
      #2;
      rst = 1'b0;
      check("idle pins", 4'hF, {select_n, drive_en_n, strobe_n, bus_oe_n});
      check("busy idle", 1'b0, busy);
      $display("test reset done");
      // corner addresses then random ones, polled and timed writes alternating
      for (int i = 0; i < 10; i++) begin
         a = (i == 0) ? 11'h000 : (i == 1) ? 11'h7FF : lfsr[10:0];
         d = lfsr[18:11];
         lfsr = step(lfsr);
         access(1'b1, i[0], a, d, 1'b0, i == 3);
         shadow[a] = d;
         exp_writes++;
         check("writes", exp_writes, writes);
         access(1'b0, 1'b0, a, 8'h00, 1'b0, 1'b0);
         check("rd_data", shadow[a], rd_data);
         access(1'b0, 1'b0, a ^ 11'h001, 8'h00, 1'b0, 1'b0);
         check("neighbour", shadow[a ^ 11'h001], rd_data);
      end
      $display("test writes done");
      // poll compare on a read: match ends early, mismatch times out
      access(1'b0, 1'b1, a, shadow[a], 1'b0, 1'b0);
      access(1'b0, 1'b1, a, ~shadow[a], 1'b1, 1'b0);
      check("writes idle", exp_writes, writes);
      $display("test poll done");
      results();
   end
endmodule // eeprom_async_byte_access_bench
